// ### design/dual_serial_port.sv
// Purpose: Up to two serial ports with four modes on a byte-wide register bus.
// Assumes: Timer overflows arrive as one-cycle pulses on the core clock.
// Notes:   Operation
// Operation
// - Two mode bits select modes zero to three
// - Mode 1 frame: start, eight data, stop
// - Mode 1 stores stop bit as ninth flag
// - Multiprocessor modes 2/3: ninth zero, no flag
// - Multiprocessor mode 1: flag needs valid stop
// - Mode 0 rate clk/12, or clk/4
// - Async receive only while receive enable set; mode 0 needs it only to start
// - Modes 2/3 send transmit-ninth control bit
// - Ninth flag: ninth bit, or stop bit
// - Transmit flag set by hardware, cleared by software
// - Receive flag set by hardware, cleared by software
// - Mode 0: data pins plus shift clock out
// - Mode 0 buffer write shifts byte out LSB-first
// - Mode 0 receive starts on enable, flag clear
// - Mode 0 receive flag one shift-clock period after the eighth bit, then halt; transmit flag at the eighth bit's end
// - Port 0 picks either timer, port 1 narrow
// - Timer overflow pulses divided by sixteen
// - Rate-double bit halves narrow overflow when clear
// - Separate wide-timer selects for transmit and receive
// - Wide timer counts clk/2 in baud use
// - No framing check, no address compare
// - Build parameter sets zero, one or two ports
// - Sixteen samples per bit, realigned on start edge
// - Majority of three; false start aborts
// - Load only when flag clear; with multiprocessor set, ninth or stop bit must be high
`timescale 1ns/1ns
`default_nettype none

module serial_port_unit
  import dual_serial_port_pkg::*;
#(
  parameter bit HAS_WIDE = 1'b1
) (
  // Clock, reset, enable
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic       clk_en,
  // Register access
  input  wire logic       wr_control,
  input  wire logic       wr_buffer,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] control_reg,
  output logic      [7:0] rx_hold_reg,
  output logic            tx_ready_reg,
  // Baud sources
  input  wire logic       rate_double,
  input  wire logic       narrow_ovf,
  input  wire logic       wide_ovf,
  input  wire logic       tx_wide_sel,
  input  wire logic       rx_wide_sel,
  // Line pins
  input  wire logic       serial_in,
  output logic            serial_out_reg,
  output logic            sync_data_out_reg
);
  serial_mode_t mode;
  rx_state_t    rx_state_reg;
  tx_state_t    tx_state_reg;
  logic [2:0]   in_sync_reg;
  logic         line_reg, line_prev_reg;
  logic         narrow_half_reg;
  logic [1:0]   fixed_cnt_reg;
  logic [3:0]   tx16_reg, rx16_reg;
  logic [3:0]   sync_cnt_reg;
  logic [3:0]   tx_idx_reg, rx_idx_reg;
  logic [10:0]  tx_shift_reg;
  logic [3:0]   tx_bits_reg;
  logic [7:0]   rx_shift_reg;
  logic         smp_a_reg, smp_b_reg;
  logic [7:0]   fifo0_reg, fifo1_reg;
  logic [1:0]   fifo_cnt_reg, fifo_cnt_next;
  logic         narrow_tick, fixed_tick, tx_tick, rx_tick, tx_roll;
  logic         sync_active, sync_rise, sync_end, majority, fall;
  logic [3:0]   sync_div;
  logic         fifo_push, fifo_pop, tx_done_evt, rx_async_evt, rx_sync_evt;

  // Mode decode and control shortcuts
  assign mode = serial_mode_t'({control_reg[MODE_HI_BIT], control_reg[MODE_LO_BIT]});

  // Input synchroniser; level moves only when stages two and three agree
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      in_sync_reg <= 3'h7;
      line_reg    <= 1'b1;
    end else if (clk_en) begin
      in_sync_reg <= {in_sync_reg[1:0], serial_in};
      if (in_sync_reg[1] == in_sync_reg[2]) begin
        line_reg <= in_sync_reg[2];
      end
    end
  end

  // Narrow timer overflow halved unless rate doubling is set
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      narrow_half_reg <= 1'b0;
    end else if (clk_en && narrow_ovf) begin
      narrow_half_reg <= ~narrow_half_reg;
    end
  end
  assign narrow_tick = narrow_ovf & (rate_double | narrow_half_reg);

  // Fixed mode 2 tick from the core clock
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      fixed_cnt_reg <= 2'h0;
    end else if (clk_en) begin
      fixed_cnt_reg <= fixed_tick ? 2'h0 : fixed_cnt_reg + 2'h1;
    end
  end
  assign fixed_tick = (fixed_cnt_reg == (rate_double ? FIXED_TICK_FAST : FIXED_TICK_SLOW));

  // Wide timer is only reachable on a port built with it
  assign tx_tick = (mode == MODE_ASYNC9_FIX) ? fixed_tick :
                   (HAS_WIDE && tx_wide_sel) ? wide_ovf : narrow_tick;
  assign rx_tick = (mode == MODE_ASYNC9_FIX) ? fixed_tick :
                   (HAS_WIDE && rx_wide_sel) ? wide_ovf : narrow_tick;
  assign tx_roll = tx_tick & (tx16_reg == OVERSAMPLE_LAST);

  // Transmit divide-by-sixteen runs free; frames start on its rollover
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tx16_reg <= 4'h0;
    end else if (clk_en && tx_tick) begin
      tx16_reg <= tx16_reg + 4'h1;
    end
  end

  // Receive sampling counter, realigned on a start edge
  assign fall = line_prev_reg & ~line_reg;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rx16_reg      <= 4'h0;
      line_prev_reg <= 1'b1;
      smp_a_reg     <= 1'b1;
      smp_b_reg     <= 1'b1;
    end else if (clk_en && rx_tick) begin
      line_prev_reg <= line_reg;
      if (rx_state_reg == RX_IDLE && fall) begin
        rx16_reg <= 4'h1;
      end else begin
        rx16_reg <= rx16_reg + 4'h1;
      end
      if (rx16_reg == SAMPLE_FIRST) begin
        smp_a_reg <= line_reg;
      end
      if (rx16_reg == SAMPLE_SECOND) begin
        smp_b_reg <= line_reg;
      end
    end
  end
  assign majority = (smp_a_reg & smp_b_reg) | (smp_a_reg & line_reg) |
                    (smp_b_reg & line_reg);

  // Mode 0 shift clock divider, shared by both directions
  assign sync_active = (tx_state_reg == TX_SYNC) || (rx_state_reg == RX_SYNC) ||
                       (rx_state_reg == RX_SYNC_TAIL);
  assign sync_div  = control_reg[MULTIPROC_BIT] ? SYNC_DIV_FAST : SYNC_DIV_SLOW;
  assign sync_end  = sync_active && (sync_cnt_reg == sync_div - 4'h1);
  assign sync_rise = sync_active && (sync_cnt_reg == {1'b0, sync_div[3:1]} - 4'h1);
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sync_cnt_reg <= 4'h0;
    end else if (clk_en) begin
      sync_cnt_reg <= (!sync_active || sync_end) ? 4'h0 : sync_cnt_reg + 4'h1;
    end
  end

  // Two-entry transmit buffer; writes beyond it are refused
  assign fifo_push = wr_buffer && (fifo_cnt_reg != FIFO_DEPTH);
  assign fifo_pop  = (tx_state_reg == TX_IDLE) && (fifo_cnt_reg != 2'h0) &&
                     ((mode != MODE_SYNC) || (rx_state_reg == RX_IDLE));
  always_comb begin
    fifo_cnt_next = fifo_cnt_reg;
    if (fifo_push && !fifo_pop) begin
      fifo_cnt_next = fifo_cnt_reg + 2'h1;
    end else if (fifo_pop && !fifo_push) begin
      fifo_cnt_next = fifo_cnt_reg - 2'h1;
    end
  end
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      fifo0_reg    <= BUFFER_RESET;
      fifo1_reg    <= BUFFER_RESET;
      fifo_cnt_reg <= 2'h0;
      tx_ready_reg <= 1'b1;
    end else if (clk_en) begin
      fifo_cnt_reg <= fifo_cnt_next;
      tx_ready_reg <= (fifo_cnt_next != FIFO_DEPTH);
      if (fifo_pop) begin
        fifo0_reg <= fifo1_reg;
      end
      if (fifo_push) begin
        if (fifo_cnt_reg == 2'h0 || (fifo_cnt_reg == 2'h1 && fifo_pop)) begin
          fifo0_reg <= wr_data;
        end else begin
          fifo1_reg <= wr_data;
        end
      end
    end
  end

  // Transmit flag moment: stop bit placed, or eighth sync bit ended
  assign tx_done_evt = clk_en &&
    ((tx_state_reg == TX_ASYNC && tx_roll && tx_idx_reg == tx_bits_reg - 4'h2) ||
     (tx_state_reg == TX_SYNC && sync_end && tx_idx_reg == SYNC_LAST_INDEX));

  // Transmitter
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tx_state_reg <= TX_IDLE;
      tx_shift_reg <= 11'h7ff;
      tx_idx_reg   <= 4'h0;
      tx_bits_reg  <= TX_BITS_TEN;
    end else if (clk_en) begin
      case (tx_state_reg)
        TX_IDLE: begin
          tx_idx_reg <= 4'h0;
          if (fifo_pop && mode == MODE_SYNC) begin
            tx_shift_reg <= {3'h7, fifo0_reg};
            tx_state_reg <= TX_SYNC;
          end else if (fifo_pop) begin
            // Mode 1 pads with a second stop so one shifter serves all
            tx_shift_reg <= {1'b1, (mode == MODE_ASYNC8) ? 1'b1 : control_reg[TX_NINTH_BIT],
                             fifo0_reg, 1'b0};
            tx_bits_reg  <= (mode == MODE_ASYNC8) ? TX_BITS_TEN : TX_BITS_ELEVEN;
            tx_state_reg <= TX_WAIT;
          end
        end
        TX_WAIT: begin
          if (tx_roll) begin
            tx_state_reg <= TX_ASYNC;
          end
        end
        TX_ASYNC: begin
          if (tx_roll) begin
            if (tx_idx_reg == tx_bits_reg - 4'h1) begin
              tx_state_reg <= TX_IDLE;
            end else begin
              tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
              tx_idx_reg   <= tx_idx_reg + 4'h1;
            end
          end
        end
        TX_SYNC: begin
          if (sync_end) begin
            tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
            tx_idx_reg   <= tx_idx_reg + 4'h1;
            if (tx_idx_reg == SYNC_LAST_INDEX) begin
              tx_state_reg <= TX_IDLE;
            end
          end
        end
        default: tx_state_reg <= TX_IDLE;
      endcase
    end
  end

  // Line drivers; shift clock idles high and falls with each bit
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      serial_out_reg    <= 1'b1;
      sync_data_out_reg <= 1'b1;
    end else if (clk_en) begin
      if (sync_active) begin
        serial_out_reg    <= (sync_cnt_reg >= {1'b0, sync_div[3:1]});
        sync_data_out_reg <= (tx_state_reg == TX_SYNC) ? tx_shift_reg[0] : 1'b1;
      end else begin
        serial_out_reg    <= (tx_state_reg == TX_ASYNC) ? tx_shift_reg[0] : 1'b1;
        sync_data_out_reg <= 1'b1;
      end
    end
  end

  // Frame end: stop bit in mode 1, ninth bit in modes 2 and 3; no framing check
  assign rx_async_evt = clk_en && rx_tick && rx_state_reg == RX_ASYNC &&
                        rx16_reg == SAMPLE_DECIDE && rx_idx_reg == RX_LAST_INDEX &&
                        !control_reg[RX_DONE_BIT] &&
                        (!control_reg[MULTIPROC_BIT] || majority);
  assign rx_sync_evt  = clk_en && rx_state_reg == RX_SYNC_TAIL && sync_end;

  // Receiver
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rx_state_reg <= RX_IDLE;
      rx_idx_reg   <= 4'h0;
      rx_shift_reg <= BUFFER_RESET;
    end else if (clk_en) begin
      case (rx_state_reg)
        RX_IDLE: begin
          rx_idx_reg <= 4'h0;
          if (control_reg[RX_ENABLE_BIT]) begin
            if (mode == MODE_SYNC) begin
              if (!control_reg[RX_DONE_BIT] && tx_state_reg == TX_IDLE &&
                  fifo_cnt_reg == 2'h0) begin
                rx_state_reg <= RX_SYNC;
              end
            end else if (rx_tick && fall) begin
              rx_state_reg <= RX_ASYNC;
            end
          end
        end
        RX_ASYNC: begin
          if (!control_reg[RX_ENABLE_BIT] || mode == MODE_SYNC) begin
            rx_state_reg <= RX_IDLE;
          end else if (rx_tick && rx16_reg == SAMPLE_DECIDE) begin
            rx_idx_reg <= rx_idx_reg + 4'h1;
            if (rx_idx_reg == 4'h0 && majority) begin
              rx_state_reg <= RX_IDLE;
            end else if (rx_idx_reg == RX_LAST_INDEX) begin
              rx_state_reg <= RX_IDLE;
            end else if (rx_idx_reg != 4'h0) begin
              rx_shift_reg <= {majority, rx_shift_reg[7:1]};
            end
          end
        end
        RX_SYNC: begin
          if (sync_rise) begin
            rx_shift_reg <= {line_reg, rx_shift_reg[7:1]};
          end
          if (sync_end) begin
            rx_idx_reg <= rx_idx_reg + 4'h1;
            if (rx_idx_reg == SYNC_LAST_INDEX) begin
              rx_state_reg <= RX_SYNC_TAIL;
            end
          end
        end
        RX_SYNC_TAIL: begin
          if (sync_end) begin
            rx_state_reg <= RX_IDLE;
          end
        end
        default: rx_state_reg <= RX_IDLE;
      endcase
    end
  end

  // Receive holding register survives ongoing transmission
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rx_hold_reg <= BUFFER_RESET;
    end else if (clk_en) begin
      if (rx_async_evt || rx_sync_evt) begin
        rx_hold_reg <= rx_shift_reg;
      end
    end
  end

  // Control register; hardware set wins over a software clear
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      control_reg <= CONTROL_RESET;
    end else if (clk_en) begin
      if (wr_control) begin
        control_reg <= wr_data;
      end
      if (tx_done_evt) begin
        control_reg[TX_DONE_BIT] <= 1'b1;
      end
      if (rx_async_evt || rx_sync_evt) begin
        control_reg[RX_DONE_BIT] <= 1'b1;
      end
      if (rx_async_evt) begin
        control_reg[RX_NINTH_BIT] <= majority;
      end
    end
  end

endmodule : serial_port_unit

module dual_serial_port
  import dual_serial_port_pkg::*;
#(
  parameter int NUM_PORTS = 2
) (
  // Clock, reset, enable
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic       clk_en,
  // Special-function-register bus
  input  wire logic [7:0] sfr_addr,
  input  wire logic [7:0] sfr_data_in,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  output logic      [7:0] sfr_data_out,
  output logic            sfr_hit,
  // Baud sources and their selects
  input  wire logic       port0_rate_double,
  input  wire logic       port1_rate_double,
  input  wire logic       narrow_timer_overflow,
  input  wire logic       wide_timer_overflow,
  input  wire logic       tx_timer_select,
  input  wire logic       rx_timer_select,
  output logic            wide_timer_baud_mode,
  // Port 0 pins and buffer status
  input  wire logic       port0_serial_in,
  output logic            port0_serial_out,
  output logic            port0_sync_data_out,
  output logic            port0_tx_ready,
  // Port 1 pins and buffer status
  input  wire logic       port1_serial_in,
  output logic            port1_serial_out,
  output logic            port1_sync_data_out,
  output logic            port1_tx_ready
);
  logic [7:0] ctl [2];
  logic [7:0] hold [2];
  logic [1:0] sout, sdata, rdy, sin, rdbl;
  logic [7:0] ctl_addr [2];
  logic [7:0] buf_addr [2];

  assign ctl_addr[0] = PORT0_CONTROL_ADDR;
  assign ctl_addr[1] = PORT1_CONTROL_ADDR;
  assign buf_addr[0] = PORT0_BUFFER_ADDR;
  assign buf_addr[1] = PORT1_BUFFER_ADDR;
  assign sin  = {port1_serial_in, port0_serial_in};
  assign rdbl = {port1_rate_double, port0_rate_double};

  // Ports present by build choice; absent ones idle high
  for (genvar p = 0; p < 2; p++) begin : g_port
    if (p < NUM_PORTS) begin : g_on
      serial_port_unit #(.HAS_WIDE(p == 0)) u_port (
        .clk_sys           (clk_sys),
        .rstn              (rstn),
        .clk_en            (clk_en),
        .wr_control        (sfr_wr && sfr_addr == ctl_addr[p]),
        .wr_buffer         (sfr_wr && sfr_addr == buf_addr[p]),
        .wr_data           (sfr_data_in),
        .control_reg       (ctl[p]),
        .rx_hold_reg       (hold[p]),
        .tx_ready_reg      (rdy[p]),
        .rate_double       (rdbl[p]),
        .narrow_ovf        (narrow_timer_overflow),
        .wide_ovf          (wide_timer_overflow),
        .tx_wide_sel       (tx_timer_select),
        .rx_wide_sel       (rx_timer_select),
        .serial_in         (sin[p]),
        .serial_out_reg    (sout[p]),
        .sync_data_out_reg (sdata[p])
      );
    end else begin : g_off
      assign ctl[p]   = CONTROL_RESET;
      assign hold[p]  = BUFFER_RESET;
      assign rdy[p]   = 1'b0;
      assign sout[p]  = 1'b1;
      assign sdata[p] = 1'b1;
    end
  end

  assign port0_serial_out    = sout[0];
  assign port0_sync_data_out = sdata[0];
  assign port0_tx_ready      = rdy[0];
  assign port1_serial_out    = sout[1];
  assign port1_sync_data_out = sdata[1];
  assign port1_tx_ready      = rdy[1];

  // Registered read port; unmapped or absent addresses read zero
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sfr_data_out <= 8'h00;
      sfr_hit      <= 1'b0;
    end else if (clk_en) begin
      sfr_data_out <= 8'h00;
      sfr_hit      <= 1'b0;
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (sfr_rd && sfr_addr == ctl_addr[p]) begin
          sfr_data_out <= ctl[p];
          sfr_hit      <= 1'b1;
        end
        if (sfr_rd && sfr_addr == buf_addr[p]) begin
          sfr_data_out <= hold[p];
          sfr_hit      <= 1'b1;
        end
      end
    end
  end

  // Tells the wide timer to count clk/2 while it feeds port 0
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wide_timer_baud_mode <= 1'b0;
    end else if (clk_en) begin
      wide_timer_baud_mode <= (NUM_PORTS > 0) && (tx_timer_select || rx_timer_select);
    end
  end

endmodule : dual_serial_port

`default_nettype wire

// ### design/dual_serial_port_pkg.sv
// Purpose: Shared constants and types for the dual serial port block.
// Assumes: Byte-wide special-function-register bus, single core clock.
// Notes:   Field positions index the eight-bit control register.
package dual_serial_port_pkg;

  // Register addresses on the special-function-register bus
  localparam logic [7:0] PORT0_CONTROL_ADDR = 8'h98;
  localparam logic [7:0] PORT0_BUFFER_ADDR  = 8'h99;
  localparam logic [7:0] PORT1_CONTROL_ADDR = 8'hc0;
  localparam logic [7:0] PORT1_BUFFER_ADDR  = 8'hc1;

  // Control register field positions
  localparam int MODE_HI_BIT    = 7;
  localparam int MODE_LO_BIT    = 6;
  localparam int MULTIPROC_BIT  = 5;
  localparam int RX_ENABLE_BIT  = 4;
  localparam int TX_NINTH_BIT   = 3;
  localparam int RX_NINTH_BIT   = 2;
  localparam int TX_DONE_BIT    = 1;
  localparam int RX_DONE_BIT    = 0;

  // Reset values
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] BUFFER_RESET  = 8'h00;

  // Serial modes as decoded from the two mode bits
  typedef enum logic [1:0] {
    MODE_SYNC        = 2'b00,
    MODE_ASYNC8      = 2'b01,
    MODE_ASYNC9_FIX  = 2'b10,
    MODE_ASYNC9_TMR  = 2'b11
  } serial_mode_t;

  // Receiver and transmitter states
  typedef enum logic [1:0] {
    RX_IDLE      = 2'b00,
    RX_ASYNC     = 2'b01,
    RX_SYNC      = 2'b10,
    RX_SYNC_TAIL = 2'b11
  } rx_state_t;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_WAIT  = 2'b01,
    TX_ASYNC = 2'b10,
    TX_SYNC  = 2'b11
  } tx_state_t;

  // Timing counts in core clock cycles
  localparam logic [3:0] SYNC_DIV_SLOW   = 4'hc;  // Shift clock at clk/12
  localparam logic [3:0] SYNC_DIV_FAST   = 4'h4;  // Shift clock at clk/4
  localparam logic [1:0] FIXED_TICK_SLOW = 2'h3;  // 16x tick every 4 clocks, clk/64 baud
  localparam logic [1:0] FIXED_TICK_FAST = 2'h1;  // 16x tick every 2 clocks, clk/32 baud

  // Bit and sample counts
  localparam logic [3:0] OVERSAMPLE_LAST = 4'hf;  // Sixteen ticks per bit
  localparam logic [3:0] SAMPLE_FIRST    = 4'h7;
  localparam logic [3:0] SAMPLE_SECOND   = 4'h8;
  localparam logic [3:0] SAMPLE_DECIDE   = 4'h9;
  localparam logic [3:0] RX_LAST_INDEX   = 4'h9;  // Stop bit in mode 1, ninth bit otherwise
  localparam logic [3:0] TX_BITS_TEN     = 4'ha;
  localparam logic [3:0] TX_BITS_ELEVEN  = 4'hb;
  localparam logic [3:0] SYNC_LAST_INDEX = 4'h7;
  localparam logic [1:0] FIFO_DEPTH      = 2'h2;

endpackage : dual_serial_port_pkg

// ### verification/serial_port_checker_assertions.sv
// Purpose: Port-level assertions for the dual serial port.
// Assumes: Clock enable held high; only port 0 pins are watched.
// Notes:   Helper keeps port 0 mode and rate bits as last written.
`timescale 1ns/1ns
`default_nettype none
module serial_port_checker
  import dual_serial_port_pkg::*;
#(
  parameter int NUM_PORTS = 2
) (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       rstn,
  // Register bus
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_data_in,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_data_out,
  input wire logic       sfr_hit,
  // Baud select and port 0 pins
  input wire logic       tx_timer_select,
  input wire logic       wide_timer_baud_mode,
  input wire logic       port0_serial_out,
  input wire logic       port0_sync_data_out
);
  logic [2:0] mode_reg;
  // Mode and rate bits change only by software, so a shadow copy is exact
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) mode_reg <= 3'h0;
    else if (sfr_wr && sfr_addr == PORT0_CONTROL_ADDR) mode_reg <= sfr_data_in[7:5];
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  chk_read_hit: assert property (sfr_rd && sfr_addr == 8'h98 && NUM_PORTS > 0 |=> sfr_hit)
    else $error("control read gave no hit");
  chk_unmapped_quiet: assert property (sfr_rd && sfr_addr[7:1] != 7'h4c &&
    sfr_addr[7:1] != 7'h60 |=> !sfr_hit && sfr_data_out == 8'h00) else $error("unmapped read");
  chk_wide_baud: assert property (tx_timer_select |=> wide_timer_baud_mode)
    else $error("wide timer not in baud mode");
  chk_sync_idle: assert property (mode_reg[2:1] != 2'b00 && $stable(mode_reg)
    |-> port0_sync_data_out) else $error("sync data out active in async mode");
  chk_start_low: assert property (mode_reg[2:1] != 2'b00 && $fell(port0_serial_out)
    |-> !port0_serial_out [*8]) else $error("start bit too short");
  chk_fast_shift: assert property (mode_reg == 3'b001 && $fell(port0_serial_out)
    |-> !port0_serial_out [*2] ##1 port0_serial_out) else $error("fast shift clock wrong");
  chk_slow_shift: assert property (mode_reg == 3'b000 && $fell(port0_serial_out)
    |-> !port0_serial_out [*6] ##1 port0_serial_out) else $error("slow shift clock wrong");
  chk_data_steady: assert property (mode_reg[2:1] == 2'b00 && $rose(port0_serial_out)
    |-> $stable(port0_sync_data_out)) else $error("data moved at shift clock rise");
  // Main scenarios reached
  cover property (mode_reg == 3'b001 && $fell(port0_serial_out));
  cover property (mode_reg[2:1] == 2'b10 && $fell(port0_serial_out));
  cover property (sfr_hit);
endmodule : serial_port_checker
bind dual_serial_port serial_port_checker #(.NUM_PORTS(NUM_PORTS)) serial_port_checker_i (
  .clk_sys, .rstn, .sfr_addr, .sfr_data_in, .sfr_wr, .sfr_rd, .sfr_data_out, .sfr_hit,
  .tx_timer_select, .wide_timer_baud_mode, .port0_serial_out, .port0_sync_data_out
);
`default_nettype wire

// ### verification/remote_node.sv
// Purpose: Remote serial node on the far side of port 0.
// Assumes: Fixed bit period in core clocks; line idles high.
// Notes:   Frames go out on request and are captured at mid-bit.
`timescale 1ns/1ns
`default_nettype none
module remote_node #(
  parameter int BIT = 32
) (
  // Clock
  input  wire logic clk_sys,
  // Line
  input  wire logic line_in,
  output var  logic line_out
);
  logic [10:0] got   = 11'h000;
  int          nbits = 10;
  initial line_out = 1'b1;
  // Mid-bit capture after a falling edge, start bit in bit 0
  always begin
    @(negedge line_in);
    repeat (BIT / 2) @(posedge clk_sys);
    for (int i = 0; i < nbits; i++) begin
      got[i] = line_in;
      repeat (BIT) @(posedge clk_sys);
    end
  end
  // Low bit first; line back to idle high after the frame
  task automatic send(input logic [10:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      line_out <= f[i];
      repeat (BIT) @(posedge clk_sys);
    end
    line_out <= 1'b1;
  endtask : send
endmodule : remote_node
`default_nettype wire

// ### verification/tb.sv
// Purpose: Self-checking bench for the dual serial port.
// Assumes: Overflow every 2nd clock, rate doubling on: 32 clocks a bit.
// Notes:   Port 1 loops back on itself; only its reset register reads are checked.
`timescale 1ns/1ns
`default_nettype none
module tb;
  import dual_serial_port_pkg::*;
  typedef struct packed {
    logic [1:0] mode;
    logic       mp;
    logic       tb8;
    logic [7:0] data;
    logic       rxb;
    logic       flag;
  } row_t;
  // Mode, multiproc, ninth out, byte, ninth or stop in, flag expected
  row_t       rows [6] = '{'{2'b01, 1'b0, 1'b0, 8'ha5, 1'b1, 1'b1},
    '{2'b01, 1'b1, 1'b1, 8'h3c, 1'b0, 1'b0}, '{2'b10, 1'b1, 1'b1, 8'h5a, 1'b0, 1'b0},
    '{2'b10, 1'b1, 1'b0, 8'h81, 1'b1, 1'b1}, '{2'b11, 1'b0, 1'b1, 8'h7e, 1'b0, 1'b1},
    '{2'b01, 1'b0, 1'b0, 8'hc3, 1'b0, 1'b1}};
  logic [7:0] addrs [5] = '{8'h98, 8'h99, 8'hc0, 8'hc1, 8'h55};
  logic       clk_sys = 1'b0, rstn = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0, ovf = 1'b0;
  logic       tx_sel = 1'b0, m0 = 1'b0, sfr_hit, baud, p0_out, p0_sync, p0_rdy, p1_out;
  logic       node_out, h, en = 1'b1;
  logic [7:0] sfr_addr = 8'h00, sfr_data_in = 8'h00, sfr_data_out, d, sh, hold = 8'h00;
  int         num_errors = 0, cmp_count = 0, nb;
  dual_serial_port #(.NUM_PORTS(2)) dual_serial_port_i (
    .clk_sys, .rstn, .clk_en(en), .sfr_addr, .sfr_data_in, .sfr_wr, .sfr_rd,
    .sfr_data_out, .sfr_hit, .port0_rate_double(1'b1), .port1_rate_double(1'b1),
    .narrow_timer_overflow(ovf), .wide_timer_overflow(1'b0), .tx_timer_select(tx_sel),
    .rx_timer_select(tx_sel), .wide_timer_baud_mode(baud), .port0_serial_in(node_out),
    .port0_serial_out(p0_out), .port0_sync_data_out(p0_sync), .port0_tx_ready(p0_rdy),
    .port1_serial_in(p1_out), .port1_serial_out(p1_out), .port1_sync_data_out(),
    .port1_tx_ready());
  remote_node #(.BIT(32)) remote_node_i (.clk_sys, .line_in(p0_out), .line_out(node_out));
  // Clock, and an overflow every second cycle
  initial forever #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) ovf <= ~ovf;
  // Shift-clock rise is the sampling point of a mode 0 receiver
  always @(posedge p0_out) if (m0) sh = {p0_sync, sh[7:1]};
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    sfr_addr    <= a;
    sfr_data_in <= v;
    sfr_wr      <= 1'b1;
    @(posedge clk_sys);
    sfr_wr <= 1'b0;
    @(posedge clk_sys);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] q, output logic hq);
    sfr_addr <= a;
    sfr_rd   <= 1'b1;
    @(posedge clk_sys);
    sfr_rd <= 1'b0;
    #1;
    q  = sfr_data_out;
    hq = sfr_hit;
    @(posedge clk_sys);
  endtask : rd
  task automatic chk(input logic [10:0] g, input logic [10:0] e);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict
  // Watchdog well past the run of about 4300 cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    print_verdict();
  end
  // Main sequence
  initial begin
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    for (int i = 0; i < 5; i++) begin
      rd(addrs[i], d, h);
      chk({2'b00, h, d}, {2'b00, i < 4, 8'h00});
    end
    chk({10'h0, p0_rdy}, 11'h001);
    tx_sel <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk({10'h0, baud}, 11'h001);
    tx_sel <= 1'b0;
    $display("test reset done");
    for (int r = 0; r < 6; r++) begin
      nb = (rows[r].mode == 2'b01) ? 10 : 11;
      remote_node_i.nbits = nb;
      remote_node_i.got = 11'h000;
      wr(8'h98, {rows[r].mode, rows[r].mp, 1'b1, rows[r].tb8, 3'b000});
      wr(8'h99, rows[r].data);
      remote_node_i.send({1'b1, rows[r].rxb, rows[r].data, 1'b0}, nb);
      repeat (96) @(posedge clk_sys);
      chk(remote_node_i.got, (nb == 10) ? {2'b01, rows[r].data, 1'b0}
        : {1'b1, rows[r].tb8, rows[r].data, 1'b0});
      rd(8'h98, d, h);
      chk({3'b000, d}, {3'b000, rows[r].mode, rows[r].mp, 1'b1, rows[r].tb8,
        rows[r].rxb & rows[r].flag, 1'b1, rows[r].flag});
      if (rows[r].flag) hold = rows[r].data;
      rd(8'h99, d, h);
      chk({3'b000, d}, {3'b000, hold});
      $display("test row %0d done", r);
    end
    // One word to the shifter and two in the buffer fill it
    wr(8'h98, 8'h80);
    repeat (3) wr(8'h99, 8'h11);
    repeat (2) @(posedge clk_sys);
    chk({10'h0, p0_rdy}, 11'h000);
    repeat (1300) @(posedge clk_sys);
    chk({10'h0, p0_rdy}, 11'h001);
    $display("test buffer done");
    for (int m = 1; m >= 0; m--) begin
      sh = 8'h00;
      m0 = 1'b1;
      wr(8'h98, {2'b00, 1'(m), 5'b00000});
      wr(8'h99, m ? 8'h96 : 8'h4b);
      repeat (140) @(posedge clk_sys);
      chk({3'b000, sh}, {3'b000, m ? 8'h96 : 8'h4b});
      rd(8'h98, d, h);
      chk({3'b000, d}, {3'b000, 2'b00, 1'(m), 5'b00010});
      $display("test shift rate %0d done", m);
    end
    print_verdict();
  end
endmodule : tb
`default_nettype wire
